// ===== dv/rsd_retire_model.sv
// partner model: retirement logic giving per-cycle counts to the block
// assumes: the bench supplies the pattern and an active flag each cycle
`timescale 1ns/1ns
module rsd_retire_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // stimulus
    input wire logic act,
    input wire logic [19:0] val,
    // indications
    output rsd_pkg::rsd_retire_s ret
);
    // counts of 0..3 per class each cycle, all zero while idle
    always_ff @(posedge aclk) begin
        if (!aresetn || !act) begin
            ret <= '0;
        end else begin
            ret <= val;
        end
    end
endmodule : rsd_retire_model

// ===== dv/tb_rsd_retire_event_top.sv
// self-checking bench for the retirement event select and decode block
// assumes: AXI4-Lite master here, retirement counts from the partner model
`timescale 1ns/1ns
module tb_rsd_retire_event_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, load_tag, store_tag;
    logic [31:0] rdata;
    logic act = 1'b0;
    logic [19:0] val = 20'h0;
    rsd_pkg::rsd_retire_s ret;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] s = 32'h27;

    always #50 aclk = ~aclk;

    rsd_retire_event_top u_rsd_retire_event_top (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .retire(ret), .load_tag(load_tag), .store_tag(store_tag)
    );

    rsd_retire_model u_rsd_retire_model (
        .aclk(aclk), .aresetn(aresetn), .act(act), .val(val), .ret(ret)
    );

    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nx

    // expected increment for one cycle of retirement counts
    function automatic logic [31:0] inc(input logic [6:0] ev, input logic [15:0] m,
            input logic [2:0] cs, input rsd_pkg::rsd_retire_s r);
        logic [31:0] n;
        n = 32'h0;
        for (int i = 0; i < 4; i++) begin
            if (cs == 3'h4 && ev == 7'h02 && m[i]) n += r.instr_n[i];
            if (cs == 3'h4 && ev == 7'h01 && i < 2 && m[i]) n += r.uop_n[i[0]];
            if (cs == 3'h5 && ev == 7'h06 && m[i]) n += r.br_n[i];
        end
        return n;
    endfunction : inc

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ah, wh, bh, done;
        done = 1'b0;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid && bready;
            if (bh) r = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) bready <= 1'b0;
            done = bh;
        end
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ah, rh, done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ah = arvalid && arready;
            rh = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            if (rh) rready <= 1'b0;
            done = rh;
        end
    endtask : axr

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        logic [31:0] d, e, acc;
        logic [1:0] r, tg;
        logic [6:0] ev;
        logic [15:0] m;
        logic [2:0] cs;
        logic [7:0] a;
        int k, kind, ri;
        bit odd, bad;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values and address decode
        for (int i = 0; i < 26; i++) begin
            a = 8'(i * 4);
            e = (a < 8'h18 || (a >= 8'h20 && a < 8'h38) || (a >= 8'h40 && a < 8'h58) || a == 8'h60) ? 0 : 2;
            axr(a, d, r);
            chk("reset_data", d, 32'h0);
            chk("read_resp", {30'h0, r}, e);
        end
        axw(8'h00, 32'hFFFF_FFFF, r);
        axr(8'h00, d, r);
        chk("select_fields", d, 32'hFFFF_FE00);
        axw(8'h20, 32'hFFFF_FFFF, r);
        axr(8'h20, d, r);
        chk("config_fields", d, 32'h0000_F000);
        axw(8'h18, 32'h1234_5678, r);
        chk("unmapped_write", {30'h0, r}, 32'h2);
        axw(8'h60, 32'hFFFF_FFFF, r);
        axr(8'h60, d, r);
        chk("status_read_only", d, 32'h0);
        $display("test registers done");
        // each event on three counters, last four on the wrong register
        for (int t = 0; t < 16; t++) begin
            k = t % 6;
            kind = t % 4;
            bad = t >= 12;
            odd = k == 2 || k == 3 || k == 5;
            ev = kind == 1 ? 7'h01 : kind == 2 ? 7'h06 : 7'h02;
            cs = kind == 2 ? 3'h5 : kind == 3 ? 3'h2 : 3'h4;
            m = t < 4 ? 16'h000F : {12'h0, s[3:0]};
            // hand-picked single qualifiers for the per-bit checks
            if (t == 4) m = 16'h0001;
            if (t == 5) m = 16'h0002;
            if (t == 6) m = 16'h0008;
            if (kind == 1) m = m & 16'h0003;
            if (kind == 3) m = 16'h0006;
            ri = (kind == 2 ? 2 : kind == 3 ? 4 : 0) + int'(odd ^ bad);
            for (int j = 0; j < 6; j++) begin
                axw(8'(j * 4), 32'h0, r);
            end
            axw(8'(ri * 4), {ev, m, 9'h0}, r);
            axw(8'(32 + k * 4), {16'h0, cs, 1'b1, 12'h0}, r);
            e = s;
            axw(8'(64 + k * 4), e, r);
            s = nx(s);
            acc = 32'h0;
            for (int i = 0; i < 22; i++) begin
                @(posedge aclk);
                act <= i < 20;
                val <= s[19:0];
                s = nx(s);
                @(negedge aclk);
                if (!bad) acc += inc(ev, m, cs, ret);
            end
            axr(8'(64 + k * 4), d, r);
            chk("counter", d, e + acc);
            tg = kind == 3 ? 2'(1 << (ri - 4)) : 2'b00;
            chk("load_tag", {30'h0, load_tag}, {30'h0, tg});
            chk("store_tag", {30'h0, store_tag}, {30'h0, tg});
            axr(8'h60, d, r);
            chk("status", d, {28'h0, tg, tg});
            $display("test event %0d counter %0d done", kind, k + 12);
        end
        final_report();
    end
endmodule : tb_rsd_retire_event_top

// ===== hw/rsd_counter.sv
// one event counter with software load
// assumes: load and increment arrive in the same clock domain
`timescale 1ns/1ns
`include "rsd_params.svh"

module rsd_counter #(
    parameter int W = 32,
    parameter int INC_W = `RSD_CNT_W + 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic en,
    input wire logic [INC_W-1:0] inc,
    input wire logic wr,
    input wire logic [W-1:0] wdata,
    // state
    output logic [W-1:0] value
);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value <= W'(`RSD_REG_RST);
        end else if (wr) begin
            value <= wdata;
        end else if (en) begin
            value <= value + W'(inc);
        end
    end

endmodule : rsd_counter

// ===== hw/rsd_event_qual.sv
// event qualifier: turns one selection register and a select code
// into a per-cycle increment; assumes retire counts valid each cycle
`timescale 1ns/1ns
`include "rsd_params.svh"

module rsd_event_qual #(
    parameter int CNT_W = `RSD_CNT_W,
    parameter int INC_W = `RSD_CNT_W + 2
) (
    // selection
    input wire rsd_pkg::rsd_evsel_s evsel,
    input wire logic [2:0] cs,
    // retirement indications
    input wire rsd_pkg::rsd_retire_s ret,
    // result
    output logic [INC_W-1:0] inc
);

    logic [3:0][INC_W-1:0] instr_t;
    logic [3:0][INC_W-1:0] br_t;
    logic [INC_W-1:0] instr_sum;
    logic [INC_W-1:0] br_sum;
    logic [INC_W-1:0] uop_sum;

    genvar i;
    for (i = 0; i < 4; i++) begin : g_term
        assign instr_t[i] = evsel.ev_mask[i] ? INC_W'(ret.instr_n[i]) : '0; // R03
        assign br_t[i] = evsel.ev_mask[i] ? INC_W'(ret.br_n[i]) : '0; // R12
    end

    // counts as reported; a re-retired interrupted flow counts again
    assign instr_sum = instr_t[0] + instr_t[1] + instr_t[2] + instr_t[3]; // R01 R05 R14
    assign br_sum = br_t[0] + br_t[1] + br_t[2] + br_t[3]; // R14
    assign uop_sum = (evsel.ev_mask[`RSD_M_GOOD] ? INC_W'(ret.uop_n[0]) : '0) // R07
        + (evsel.ev_mask[`RSD_M_WRONG] ? INC_W'(ret.uop_n[1]) : '0); // R14

    always_comb begin
        inc = '0;
        case (cs)
            `RSD_CS_CRU_LO: begin
                if (evsel.ev_sel == `RSD_EV_INSTR_RET) begin
                    inc = instr_sum; // R02
                end else if (evsel.ev_sel == `RSD_EV_UOPS_RET) begin
                    inc = uop_sum; // R06
                end
            end
            `RSD_CS_CRU_HI: begin
                if (evsel.ev_sel == `RSD_EV_BRANCH_RET) begin
                    inc = br_sum; // R11
                end
            end
            // tagging only, never counts
            `RSD_CS_RAT: inc = '0; // R08 R10
            default: inc = '0;
        endcase
    end

endmodule : rsd_event_qual

// ===== hw/rsd_retire_event_top.sv
// retirement event select/decode with six counters behind AXI4-Lite
// assumes: retirement indications synchronous to aclk, one master
`timescale 1ns/1ns
`include "rsd_params.svh"

// Overview of operation
// R01: instruction event counts retired instructions per cycle
// R02: instruction event is code 02H with select 04H
// R03: instruction mask picks good/wrong path and tag
// R04: instruction count may vary with enable timing
// R05: interrupted complex instructions may count twice
// R06: micro-op event is code 01H with select 04H
// R07: micro-op mask bit0 good, bit1 wrong path
// R08: memory-op tagging is code 02H, select 02H
// R09: mask bit1 tags loads, bit2 tags stores
// R10: load/store tag bits never increment counters
// R11: branch event is code 06H on registers 2/3
// R12: branch mask selects four prediction outcomes
// R13: even register feeds 12,13,16; odd 14,15,17
// R14: several mask bits add all matching items
module rsd_retire_event_top #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = `RSD_CNT_W
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address channel
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // retirement indications
    input wire rsd_pkg::rsd_retire_s retire,
    // tag requests toward front end
    output logic [1:0] load_tag,
    output logic [1:0] store_tag
);

    localparam int INC_W = CNT_W + 2;
    localparam int NC = `RSD_NUM_CTR;

    rsd_pkg::rsd_evsel_s sel_q [`RSD_NUM_SEL];
    rsd_pkg::rsd_ctrcfg_s cfg_q [NC];
    rsd_pkg::rsd_evsel_s evsel_mux [NC];
    logic [INC_W-1:0] inc [NC];
    logic [31:0] cnt_val [NC];
    logic [NC-1:0] cnt_wr;

    logic aw_have_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [1:0] load_tag_q;
    logic [1:0] store_tag_q;

    logic do_write;
    logic w_sel_hit;
    logic w_cfg_hit;
    logic w_cnt_hit;
    logic w_map_hit;
    logic [2:0] w_idx;
    logic [31:0] rd_data;
    logic rd_err;

    function automatic logic in_bank(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
        in_bank = (a >= base) && (a < base + ADDR_W'(4 * `RSD_NUM_CTR)) && (a[1:0] == 2'h0);
    endfunction : in_bank

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : strb_merge

    // write channel capture, address and data in either order
    assign awready = !aw_have_q;
    assign wready = !w_have_q;
    assign do_write = aw_have_q && w_have_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (wvalid && wready) begin
            w_have_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (do_write) begin
            w_have_q <= 1'b0;
        end
    end

    assign w_sel_hit = in_bank(aw_addr_q, `RSD_OFF_SEL);
    assign w_cfg_hit = in_bank(aw_addr_q, `RSD_OFF_CFG);
    assign w_cnt_hit = in_bank(aw_addr_q, `RSD_OFF_CNT);
    assign w_map_hit = w_sel_hit || w_cfg_hit || w_cnt_hit || (aw_addr_q == `RSD_OFF_STATUS);
    assign w_idx = aw_addr_q[`RSD_IDX_MSB:`RSD_IDX_LSB];

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RSD_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= w_map_hit ? `RSD_RESP_OKAY : `RSD_RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // selection registers, reserved bits forced to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < `RSD_NUM_SEL; i++) begin
                sel_q[i] <= rsd_pkg::rsd_evsel_s'(`RSD_REG_RST);
            end
        end else if (do_write && w_sel_hit) begin
            sel_q[w_idx] <= rsd_pkg::rsd_evsel_s'(strb_merge(sel_q[w_idx], w_data_q, w_strb_q));
            sel_q[w_idx].rsvd <= '0;
        end
    end

    // counter configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NC; i++) begin
                cfg_q[i] <= rsd_pkg::rsd_ctrcfg_s'(`RSD_REG_RST);
            end
        end else if (do_write && w_cfg_hit) begin
            cfg_q[w_idx] <= rsd_pkg::rsd_ctrcfg_s'(strb_merge(cfg_q[w_idx], w_data_q, w_strb_q));
            cfg_q[w_idx].rsvd_hi <= '0;
            cfg_q[w_idx].rsvd_lo <= '0;
        end
    end

    // tag requests from the rename-stage selection registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_tag_q <= '0;
            store_tag_q <= '0;
        end else begin
            for (int r = 0; r < 2; r++) begin
                load_tag_q[r] <= (sel_q[`RSD_SEL_RAT_BASE+r].ev_sel == `RSD_EV_UOP_TYPE)
                    && sel_q[`RSD_SEL_RAT_BASE+r].ev_mask[`RSD_M_LOAD_TAG]; // R08 R09
                store_tag_q[r] <= (sel_q[`RSD_SEL_RAT_BASE+r].ev_sel == `RSD_EV_UOP_TYPE)
                    && sel_q[`RSD_SEL_RAT_BASE+r].ev_mask[`RSD_M_STORE_TAG]; // R09
            end
        end
    end

    assign load_tag = load_tag_q;
    assign store_tag = store_tag_q;

    // read path, one answer per address
    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        if (in_bank(araddr, `RSD_OFF_SEL)) begin
            rd_data = sel_q[araddr[`RSD_IDX_MSB:`RSD_IDX_LSB]];
        end else if (in_bank(araddr, `RSD_OFF_CFG)) begin
            rd_data = cfg_q[araddr[`RSD_IDX_MSB:`RSD_IDX_LSB]];
        end else if (in_bank(araddr, `RSD_OFF_CNT)) begin
            rd_data = cnt_val[araddr[`RSD_IDX_MSB:`RSD_IDX_LSB]];
        end else if (araddr == `RSD_OFF_STATUS) begin
            rd_data = {28'h0000000, store_tag_q, load_tag_q};
        end else begin
            rd_err = 1'b1;
        end
    end

    assign arready = !rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `RSD_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_data;
            rresp_q <= rd_err ? `RSD_RESP_SLVERR : `RSD_RESP_OKAY;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // counters 12..17 as indices 0..5
    genvar k;
    for (k = 0; k < NC; k++) begin : g_ctr
        localparam bit ODD = (k == 2) || (k == 3) || (k == 5);
        localparam int LO = ODD ? 1 : 0;
        localparam int HI = ODD ? 3 : 2;
        localparam int RT = ODD ? 5 : 4;
        localparam int OTHER = ODD ? 2 : 3;

        // each counter sees only its own bank's registers
        always_comb begin
            case (cfg_q[k].sel)
                `RSD_CS_CRU_LO: evsel_mux[k] = sel_q[LO]; // R13
                `RSD_CS_CRU_HI: evsel_mux[k] = sel_q[HI]; // R13
                `RSD_CS_RAT: evsel_mux[k] = sel_q[RT]; // R13
                default: evsel_mux[k] = '0;
            endcase
        end

        rsd_event_qual #(
            .CNT_W(CNT_W),
            .INC_W(INC_W)
        ) u_qual (
            .evsel(evsel_mux[k]),
            .cs(cfg_q[k].sel),
            .ret(retire),
            .inc(inc[k])
        );

        assign cnt_wr[k] = do_write && w_cnt_hit && (w_idx == 3'(k));

        // counting starts at whatever retires once enabled
        rsd_counter #(
            .W(32),
            .INC_W(INC_W)
        ) u_ctr (
            .aclk(aclk),
            .aresetn(aresetn),
            .en(cfg_q[k].en), // R04
            .inc(inc[k]),
            .wr(cnt_wr[k]),
            .wdata(strb_merge(cnt_val[k], w_data_q, w_strb_q)),
            .value(cnt_val[k])
        );

        logic counting;
        assign counting = cfg_q[k].en && !cnt_wr[k];

        a_rat_no_inc: assert property (@(posedge aclk) disable iff (!aresetn) // R10
            (counting && cfg_q[k].sel == `RSD_CS_RAT) |=> $stable(cnt_val[k]))
            else $error("counter moved on a tagging selection");

        a_instr_good_untag: assert property (@(posedge aclk) disable iff (!aresetn) // R03
            (counting && cfg_q[k].sel == `RSD_CS_CRU_LO && evsel_mux[k].ev_sel == `RSD_EV_INSTR_RET
             && evsel_mux[k].ev_mask[3:0] == 4'h1)
            |=> cnt_val[k] == $past(cnt_val[k]) + 32'($past(retire.instr_n[0])))
            else $error("good untagged instruction count wrong");

        a_instr_all_sum: assert property (@(posedge aclk) disable iff (!aresetn) // R14
            (counting && cfg_q[k].sel == `RSD_CS_CRU_LO && evsel_mux[k].ev_sel == `RSD_EV_INSTR_RET
             && evsel_mux[k].ev_mask[3:0] == 4'hF)
            |=> cnt_val[k] == $past(cnt_val[k]) + 32'($past(retire.instr_n[0]))
                + 32'($past(retire.instr_n[1])) + 32'($past(retire.instr_n[2]))
                + 32'($past(retire.instr_n[3])))
            else $error("instruction sum over mask bits wrong");

        a_uops_wrong_path: assert property (@(posedge aclk) disable iff (!aresetn) // R07
            (counting && cfg_q[k].sel == `RSD_CS_CRU_LO && evsel_mux[k].ev_sel == `RSD_EV_UOPS_RET
             && evsel_mux[k].ev_mask[1:0] == 2'h2)
            |=> cnt_val[k] == $past(cnt_val[k]) + 32'($past(retire.uop_n[1])))
            else $error("wrong path micro-op count wrong");

        a_branch_taken_mis: assert property (@(posedge aclk) disable iff (!aresetn) // R12
            (counting && cfg_q[k].sel == `RSD_CS_CRU_HI && evsel_mux[k].ev_sel == `RSD_EV_BRANCH_RET
             && evsel_mux[k].ev_mask[3:0] == 4'h8)
            |=> cnt_val[k] == $past(cnt_val[k]) + 32'($past(retire.br_n[3])))
            else $error("taken mispredicted branch count wrong");

        a_bank_binding: assert property (@(posedge aclk) disable iff (!aresetn) // R13
            (counting && cfg_q[k].sel == `RSD_CS_CRU_HI && sel_q[HI].ev_sel != `RSD_EV_BRANCH_RET
             && sel_q[OTHER].ev_sel == `RSD_EV_BRANCH_RET) |=> $stable(cnt_val[k]))
            else $error("counter followed the other bank");
    end

    sequence s_wr_taken;
        awvalid && awready && wvalid && wready && !bvalid_q;
    endsequence

    sequence s_wr_answer;
        !bvalid ##1 bvalid;
    endsequence

    a_bus_wr_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        s_wr_taken |=> s_wr_answer)
        else $error("write response not two cycles after take");

    a_bus_rd_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        (arvalid && arready) |=> rvalid && !arready)
        else $error("read answer missing");

    a_load_tag_req: assert property (@(posedge aclk) disable iff (!aresetn) // R09
        (sel_q[4].ev_sel == `RSD_EV_UOP_TYPE && sel_q[4].ev_mask[`RSD_M_LOAD_TAG])
        |=> load_tag[0])
        else $error("load tag request not raised");

endmodule : rsd_retire_event_top

// ===== pkg/rsd_params.svh
// constants for the retirement event select and decode block
// assumes: included by bare name from package and design files
`ifndef RSD_PARAMS_SVH
`define RSD_PARAMS_SVH

// per-cycle retirement count width and counter bank
`define RSD_CNT_W 2
`define RSD_NUM_CTR 6
`define RSD_NUM_SEL 6

// event select codes
`define RSD_EV_UOPS_RET 7'h01
`define RSD_EV_INSTR_RET 7'h02
`define RSD_EV_UOP_TYPE 7'h02
`define RSD_EV_BRANCH_RET 7'h06

// counter configuration select codes
`define RSD_CS_RAT 3'h2
`define RSD_CS_CRU_LO 3'h4
`define RSD_CS_CRU_HI 3'h5

// mask bit positions
`define RSD_M_GOOD 0
`define RSD_M_WRONG 1
`define RSD_M_LOAD_TAG 1
`define RSD_M_STORE_TAG 2

// register byte offsets
`define RSD_OFF_SEL 8'h00
`define RSD_OFF_CFG 8'h20
`define RSD_OFF_CNT 8'h40
`define RSD_OFF_STATUS 8'h60

// register index field within a byte address, first rename-stage register
`define RSD_IDX_MSB 4
`define RSD_IDX_LSB 2
`define RSD_SEL_RAT_BASE 4

// reset values and bus answers
`define RSD_REG_RST 32'h0000_0000
`define RSD_RESP_OKAY 2'h0
`define RSD_RESP_SLVERR 2'h2

`endif

// ===== pkg/rsd_pkg.sv
// types shared by the retirement event select and decode block
// assumes: rsd_params.svh on the include path
`include "rsd_params.svh"

package rsd_pkg;

    // event selection register layout
    typedef struct packed {
        logic [6:0] ev_sel;
        logic [15:0] ev_mask;
        logic [8:0] rsvd;
    } rsd_evsel_s;

    // counter configuration register layout
    typedef struct packed {
        logic [15:0] rsvd_hi;
        logic [2:0] sel;
        logic en;
        logic [11:0] rsvd_lo;
    } rsd_ctrcfg_s;

    // per-cycle indications from retirement logic
    typedef struct packed {
        logic [3:0][`RSD_CNT_W-1:0] br_n;
        logic [1:0][`RSD_CNT_W-1:0] uop_n;
        logic [3:0][`RSD_CNT_W-1:0] instr_n;
    } rsd_retire_s;

endpackage : rsd_pkg
